// File: rtl/nandec_error_report.sv
// ECC error-reporting registers with an AXI4-Lite slave and an interrupt
// What this block does
// (RL1) Recoverable flag set when sector errors found
// (RL2) ECC-byte flag marks single parity-byte error
// (RL3) Whole-page mode forces sectors above zero low
// (RL4) Multiple flag set when several errors found
// (RL5) Sectors six, seven follow sector size mapping
// (RL6) High status register valid only 256-byte mode
// (RL7) Each sector one nibble, top bit reserved
// (RL8) Location register: bit offset, word address
// (RL9) Single error latches location after page read
// (RL10) Writing one clears parity, zero does nothing
// (RL11) Correction type 00 page, 01 256, 10 512
// (RL12) Flags update at compare, hold until clear
`include "nandec_cfg.svh"
module nandec_error_report #(
   parameter int ADDR_W = 8                      // Register address width
) (
   input  wire logic                 clk_sys,         // System clock
   input  wire logic                 reset,           // Synchronous reset, high
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Compare results from the parity unit
   input  wire logic                 pageCheckDone,   // Stored ECC compared, one pulse
   input  wire logic [15:0]          sectorErrorFound,
   input  wire logic [15:0]          sectorParityByteErr,
   input  wire logic [15:0]          sectorManyErrors,
   input  wire logic [11:0]          failingWordIn,
   input  wire logic [3:0]           failingBitIn,
   // Controls toward the parity unit
   output logic [1:0]                correction_type, // Current correction type
   output logic                      parityClear,     // Parity reset pulse
   output logic                      irq              // Level interrupt
);
   // Stored per-sector flags
   logic [15:0] recoverable_flag;
   logic [15:0] parity_byte_error_flag;
   logic [15:0] multiple_error_flag;
   logic [11:0] failing_word_location;              // Latched word address
   logic [3:0]  failing_bit_offset;                 // Latched bit offset
   logic [15:0] sectorValid;                        // Sectors present in mode
   logic [31:0] ecc_sector_status_low;
   logic [31:0] ecc_sector_status_high;
   logic [31:0] ecc_single_error_location;
   logic [2:0]  irqStatus;                          // Sticky events
   logic [2:0]  irqEnable;                          // Event enables
   logic [2:0]  irqEvent;                           // Events this cycle
   // Write channel holding state
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0]       wData;
   logic [3:0]        wStrb;
   logic              writeFire;                    // Both halves present
   logic              writeMapped;
   logic              readMapped;
   logic [31:0]       next_rdata;

   // Sectors that exist for the current correction type
   always_comb begin
      unique case (nandec_pkg::nandec_corr_t'(correction_type))
         nandec_pkg::NANDEC_PER_256: sectorValid = 16'hFFFF;   // RL11 RL6
         nandec_pkg::NANDEC_PER_512: sectorValid = 16'h00FF;   // RL11 RL5
         nandec_pkg::NANDEC_PER_PAGE: sectorValid = 16'h0001;  // RL11 RL3
         nandec_pkg::NANDEC_RESERVED: sectorValid = 16'h0001;
      endcase
   end

   // Status views: one nibble per sector, top bit zero
   genvar gi;
   generate
      for (gi = 0; gi < `NANDEC_SECTORS; gi++) begin : g_nib
         logic [3:0] nib;
         assign nib = {1'b0,                                            // RL7
                       multiple_error_flag[gi] & sectorValid[gi],
                       parity_byte_error_flag[gi] & sectorValid[gi],
                       recoverable_flag[gi] & sectorValid[gi]};        // RL3
         if (gi < `NANDEC_SECTORS_LOW) begin : g_low
            assign ecc_sector_status_low[gi*4 +: 4] = nib;             // RL5
         end else begin : g_high
            assign ecc_sector_status_high[(gi-8)*4 +: 4] = nib;        // RL6
         end
      end
   endgenerate

   // Location register, meaningful only in whole-page mode
   assign ecc_single_error_location =
      (correction_type == 2'h0) ? {16'h0000, failing_word_location, failing_bit_offset} // RL8
                                : 32'h0000_0000;

   // Per-sector flags captured at end of page compare
   always_ff @(posedge clk_sys) begin
      if (reset || parityClear) begin
         recoverable_flag       <= 16'h0000;
         parity_byte_error_flag <= 16'h0000;
         multiple_error_flag    <= 16'h0000;
      end else if (pageCheckDone) begin
         recoverable_flag       <= sectorErrorFound & sectorValid;     // RL1 RL12
         parity_byte_error_flag <= sectorParityByteErr & sectorValid;  // RL2
         multiple_error_flag    <= sectorManyErrors & sectorValid;     // RL4
      end
   end

   // Failing location latched on a single error
   always_ff @(posedge clk_sys) begin
      if (reset || parityClear) begin
         failing_word_location <= 12'h000;
         failing_bit_offset    <= 4'h0;
      end else if (pageCheckDone && sectorErrorFound[0] && !sectorManyErrors[0]) begin
         failing_word_location <= failingWordIn;                       // RL9
         failing_bit_offset    <= failingBitIn;                        // RL9
      end
   end

   // Write address and data accepted in either order
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign writeFire     = awHeld && wHeld && !s_axi_bvalid;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (writeFire) begin
         awHeld <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wHeld <= 1'b0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end else if (writeFire) begin
         wHeld <= 1'b0;
      end
   end

   // Writable offsets
   always_comb begin
      unique case (awAddr)
         `NANDEC_OFF_CTRL, `NANDEC_OFF_MODE,
         `NANDEC_OFF_IRQ_ENABLE, `NANDEC_OFF_IRQ_CLEAR: writeMapped = 1'b1;
         default: writeMapped = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= nandec_pkg::NANDEC_OKAY;
      end else if (writeFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= writeMapped ? nandec_pkg::NANDEC_OKAY : nandec_pkg::NANDEC_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Correction type and interrupt enable registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         correction_type <= `NANDEC_MODE_RESET;
         irqEnable       <= 3'h0;
      end else if (writeFire && wStrb[0]) begin
         if (awAddr == `NANDEC_OFF_MODE) begin
            correction_type <= wData[`NANDEC_MODE_TYPE_MSB:`NANDEC_MODE_TYPE_LSB];  // RL11
         end
         if (awAddr == `NANDEC_OFF_IRQ_ENABLE) begin
            irqEnable <= wData[`NANDEC_IRQ_BITS-1:0];
         end
      end
   end

   // Parity reset pulse on a one written to the control bit
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         parityClear <= 1'b0;
      end else begin
         parityClear <= writeFire && wStrb[0] && (awAddr == `NANDEC_OFF_CTRL)
                        && wData[`NANDEC_CTRL_CLR_BIT];                // RL10
      end
   end

   // Interrupt events: compare done, single error, many errors
   assign irqEvent[`NANDEC_IRQ_DONE]   = pageCheckDone;
   assign irqEvent[`NANDEC_IRQ_SINGLE] = pageCheckDone &&
                                         |(sectorErrorFound & ~sectorManyErrors & sectorValid);
   assign irqEvent[`NANDEC_IRQ_MANY]   = pageCheckDone && |(sectorManyErrors & sectorValid);

   // Sticky status; a new event wins over a clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irqStatus <= 3'h0;
      end else if (writeFire && wStrb[0] && awAddr == `NANDEC_OFF_IRQ_CLEAR) begin
         irqStatus <= (irqStatus & ~wData[`NANDEC_IRQ_BITS-1:0]) | irqEvent;
      end else begin
         irqStatus <= irqStatus | irqEvent;
      end
   end
   assign irq = |(irqStatus & irqEnable);

   // Read data selection
   always_comb begin
      readMapped = 1'b1;
      unique case (s_axi_araddr)
         `NANDEC_OFF_MODE:       next_rdata = {26'h0, correction_type, 4'h0};
         `NANDEC_OFF_STAT_LOW:   next_rdata = ecc_sector_status_low;
         `NANDEC_OFF_STAT_HIGH:  next_rdata = ecc_sector_status_high;
         `NANDEC_OFF_LOCATION:   next_rdata = ecc_single_error_location;
         `NANDEC_OFF_IRQ_STATUS: next_rdata = {29'h0, irqStatus};
         `NANDEC_OFF_IRQ_ENABLE: next_rdata = {29'h0, irqEnable};
         `NANDEC_OFF_CTRL, `NANDEC_OFF_IRQ_CLEAR: next_rdata = 32'h0000_0000;
         default: begin
            next_rdata = 32'h0000_0000;
            readMapped = 1'b0;
         end
      endcase
   end

   // Read channel, answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= nandec_pkg::NANDEC_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= readMapped ? nandec_pkg::NANDEC_OKAY : nandec_pkg::NANDEC_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence seqClearWrite;
      writeFire && wStrb[0] && awAddr == `NANDEC_OFF_CTRL && wData[0];
   endsequence
   sequence seqFlagsGone;
      parityClear ##1 (recoverable_flag == 16'h0 && multiple_error_flag == 16'h0);
   endsequence

   AST_REC_CAPTURE: assert property (pageCheckDone && correction_type == 2'h1 && !parityClear // RL1
      |=> recoverable_flag == $past(sectorErrorFound))
      else $error("recoverable flags not captured");
   AST_ECCBYTE_CAPTURE: assert property (pageCheckDone && correction_type == 2'h2 // RL2
      && !parityClear |=> parity_byte_error_flag == ($past(sectorParityByteErr) & 16'h00FF))
      else $error("ecc-byte flags not captured");
   AST_PAGE_MODE_ZERO: assert property (correction_type == 2'h0 // RL3
      |-> ecc_sector_status_low[31:4] == 28'h0 && ecc_sector_status_high == 32'h0)
      else $error("sector above zero nonzero in page mode");
   AST_MUL_CAPTURE: assert property (pageCheckDone && correction_type == 2'h1 && !parityClear // RL4
      |=> ##1 ecc_sector_status_high[14] == ($past(sectorManyErrors[11], 2)
                                             && correction_type == 2'h1))
      else $error("multiple flag wrong");
   AST_HIGH_ONLY_256: assert property (correction_type != 2'h1 // RL6
      |-> ecc_sector_status_high == 32'h0)
      else $error("high status set outside 256-byte mode");
   AST_NIBBLE_RESERVED: assert property (((ecc_sector_status_low | ecc_sector_status_high) // RL7
      & 32'h8888_8888) == 32'h0)
      else $error("reserved nibble bit set");
   AST_LOCATION: assert property (pageCheckDone && !parityClear && correction_type == 2'h0 // RL9
      && sectorErrorFound[0] && !sectorManyErrors[0]
      |=> ecc_single_error_location[15:4] == $past(failingWordIn)) // RL8
      else $error("location not latched");
   AST_PARITY_CLEAR: assert property (seqClearWrite |=> seqFlagsGone) // RL10
      else $error("parity clear did not act");
   AST_NO_CLEAR_ON_ZERO: assert property (writeFire && awAddr == `NANDEC_OFF_CTRL // RL10
      && !wData[0] |=> !parityClear)
      else $error("zero write caused a parity clear");
   AST_HOLD: assert property (!pageCheckDone && !parityClear // RL12
      |=> $stable(recoverable_flag) && $stable(failing_word_location))
      else $error("flags changed without a compare");
   AST_SECTOR_512: assert property (correction_type == 2'h2 |-> sectorValid == 16'h00FF) // RL11 RL5
      else $error("512-byte mode sector map wrong");

   // Whole-page capture touches sector zero only
   AST_REC_PAGE: assert property (pageCheckDone && correction_type == 2'h0 && !parityClear // RL1
      |=> recoverable_flag == {15'h0, $past(sectorErrorFound[0])})
      else $error("page-mode recoverable flag wrong");
   AST_ECCBYTE_PAGE: assert property (pageCheckDone && correction_type == 2'h0 // RL2
      && !parityClear |=> parity_byte_error_flag == {15'h0, $past(sectorParityByteErr[0])})
      else $error("page-mode ecc-byte flag wrong");
   // Multiple flag drops when sector zero saw at most one error
   AST_MUL_CLEAR: assert property (pageCheckDone && !parityClear && !sectorManyErrors[0] // RL4
      |=> !multiple_error_flag[0])
      else $error("multiple flag not cleared");
   // Location layout and visibility
   AST_LOC_RESERVED: assert property (ecc_single_error_location[31:16] == 16'h0000) // RL8
      else $error("location reserved bits set");
   AST_LOC_OTHER_MODE: assert property (correction_type != 2'h0 // RL8
      |-> ecc_single_error_location == 32'h0000_0000)
      else $error("location visible outside page mode");
   // Bit offset latched on a single error, kept after many
   AST_LOC_BIT: assert property (pageCheckDone && !parityClear && sectorErrorFound[0] // RL9
      && !sectorManyErrors[0] |=> failing_bit_offset == $past(failingBitIn))
      else $error("bit offset not latched");
   AST_LOC_KEEP_MANY: assert property (pageCheckDone && !parityClear && sectorManyErrors[0] // RL9
      |=> $stable(failing_word_location) && $stable(failing_bit_offset))
      else $error("location moved after multiple errors");
   // Clear pulse lasts a single cycle
   sequence seqClearPulse;
      parityClear ##1 !parityClear;
   endsequence
   AST_CLEAR_ONE_CYCLE: assert property (seqClearWrite |=> seqClearPulse) // RL10
      else $error("parity clear pulse length wrong");
   // Status views steady between compares and mode writes
   AST_STAT_HOLD: assert property (!pageCheckDone && !parityClear // RL12
      && !(writeFire && wStrb[0] && awAddr == `NANDEC_OFF_MODE)
      |=> $stable(ecc_sector_status_low) && $stable(ecc_sector_status_high))
      else $error("status changed without a compare");
   // Many-error event reaches the sticky status
   AST_IRQ_MANY: assert property (pageCheckDone && |(sectorManyErrors & sectorValid) // RL4
      |=> irqStatus[`NANDEC_IRQ_MANY])
      else $error("many-error event lost");
endmodule : nandec_error_report

// File: rtl/nandec_cfg.svh
// Offsets, field positions, reset values and counts of the ECC error-reporting block
`ifndef NANDEC_CFG_SVH
`define NANDEC_CFG_SVH
`define NANDEC_OFF_CTRL        8'h00
`define NANDEC_OFF_MODE        8'h04
`define NANDEC_OFF_STAT_LOW    8'h08
`define NANDEC_OFF_STAT_HIGH   8'h0C
`define NANDEC_OFF_LOCATION    8'h10
`define NANDEC_OFF_IRQ_STATUS  8'h14
`define NANDEC_OFF_IRQ_ENABLE  8'h18
`define NANDEC_OFF_IRQ_CLEAR   8'h1C
`define NANDEC_CTRL_CLR_BIT    0
`define NANDEC_MODE_TYPE_LSB   4
`define NANDEC_MODE_TYPE_MSB   5
`define NANDEC_MODE_RESET      2'h0
`define NANDEC_NIB_REC         0
`define NANDEC_NIB_ECC         1
`define NANDEC_NIB_MUL         2
`define NANDEC_LOC_BIT_MSB     3
`define NANDEC_LOC_WORD_LSB    4
`define NANDEC_LOC_WORD_MSB    15
`define NANDEC_SECTORS         16
`define NANDEC_SECTORS_LOW     8
`define NANDEC_IRQ_BITS        3
`define NANDEC_IRQ_DONE        0
`define NANDEC_IRQ_SINGLE      1
`define NANDEC_IRQ_MANY        2
`endif

// File: rtl/nandec_pkg.sv
// Types shared by the ECC error-reporting block
package nandec_pkg;
   // Correction type encodings
   typedef enum logic [1:0] {
      NANDEC_PER_PAGE = 2'h0,
      NANDEC_PER_256  = 2'h1,
      NANDEC_PER_512  = 2'h2,
      NANDEC_RESERVED = 2'h3
   } nandec_corr_t;
   // AXI response codes
   typedef enum logic [1:0] {
      NANDEC_OKAY   = 2'h0,
      NANDEC_SLVERR = 2'h2
   } nandec_resp_t;
endpackage : nandec_pkg

// File: sim/tb_top.sv
// Self-checking bench for the ECC error-reporting block
`include "nandec_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, reset;                      // Clock and reset
   logic [7:0]  s_axi_awaddr, s_axi_araddr;          // Bus addresses
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata;            // Bus data
   logic [3:0]  s_axi_wstrb, failingBitIn;           // Strobes, bit offset
   logic [1:0]  s_axi_bresp, s_axi_rresp, correction_type;
   logic        pageCheckDone, parityClear, irq;     // Compare strobe, outputs
   logic [15:0] sectorErrorFound, sectorParityByteErr, sectorManyErrors;
   logic [11:0] failingWordIn;                       // Word location in
   int          fails, cmp_count, clrCnt;            // Counters
   logic [1:0]  rsp;                                 // Last response
   logic [31:0] rdv;                                 // Last read data
   localparam logic [15:0] FOUND_P = 16'hB6DB;       // Per-sector patterns
   localparam logic [15:0] PBE_P   = 16'h2481;
   localparam logic [15:0] MANY_P  = 16'h4C36;

   nandec_error_report DUT (
      .clk_sys             (clk_sys),
      .reset               (reset),
      .s_axi_awaddr        (s_axi_awaddr),
      .s_axi_awvalid       (s_axi_awvalid),
      .s_axi_awready       (s_axi_awready),
      .s_axi_wdata         (s_axi_wdata),
      .s_axi_wstrb         (s_axi_wstrb),
      .s_axi_wvalid        (s_axi_wvalid),
      .s_axi_wready        (s_axi_wready),
      .s_axi_bresp         (s_axi_bresp),
      .s_axi_bvalid        (s_axi_bvalid),
      .s_axi_bready        (s_axi_bready),
      .s_axi_araddr        (s_axi_araddr),
      .s_axi_arvalid       (s_axi_arvalid),
      .s_axi_arready       (s_axi_arready),
      .s_axi_rdata         (s_axi_rdata),
      .s_axi_rresp         (s_axi_rresp),
      .s_axi_rvalid        (s_axi_rvalid),
      .s_axi_rready        (s_axi_rready),
      .pageCheckDone       (pageCheckDone),
      .sectorErrorFound    (sectorErrorFound),
      .sectorParityByteErr (sectorParityByteErr),
      .sectorManyErrors    (sectorManyErrors),
      .failingWordIn       (failingWordIn),
      .failingBitIn        (failingBitIn),
      .correction_type     (correction_type),
      .parityClear         (parityClear),
      .irq                 (irq)
   );

   // Free-running clock
   always #10 clk_sys = ~clk_sys;
   // Count clear pulses
   always @(posedge clk_sys) if (parityClear === 1'b1) clrCnt++;

   // Compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Write one word, wait for response
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, awOk, wOk;
      int   n;
      aw = 1; w = 1; n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while ((aw || w) && n < 50) begin
         @(negedge clk_sys);
         awOk = aw & s_axi_awready; wOk = w & s_axi_wready;
         @(posedge clk_sys);
         if (awOk) begin s_axi_awvalid <= 0; aw = 0; end
         if (wOk) begin s_axi_wvalid <= 0; w = 0; end
         n++;
      end
      do begin @(negedge clk_sys); n++; end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (n >= 100) fails++;
      rsp = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 0;
   endtask : wr

   // Read one word, wait for data
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin @(negedge clk_sys); n++; end while (s_axi_arready !== 1'b1 && n < 50);
      @(posedge clk_sys);
      s_axi_arvalid <= 0;
      do begin @(negedge clk_sys); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (n >= 100) fails++;
      rdv = s_axi_rdata; rsp = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 0;
   endtask : rd

   // Read and compare data
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(rdv, exp);
   endtask : rdChk

   // One compare-result pulse
   task automatic page(input logic [15:0] f, p, m, input logic [11:0] w, input logic [3:0] b);
      @(posedge clk_sys);
      sectorErrorFound <= f; sectorParityByteErr <= p; sectorManyErrors <= m;
      failingWordIn <= w; failingBitIn <= b; pageCheckDone <= 1;
      @(posedge clk_sys);
      pageCheckDone <= 0;
      @(posedge clk_sys);
   endtask : page

   // Expected status word for eight sectors
   function automatic logic [31:0] expStat(input int base, input int nv, input logic [15:0] f,
                                           input logic [15:0] p, input logic [15:0] m);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < 8; i++)
         if (base + i < nv) v[4*i +: 4] = {1'b0, m[base+i], p[base+i], f[base+i]};
      return v;
   endfunction : expStat

   // Reset values
   task automatic t_reset();
      check({30'h0, correction_type}, 32'h0);
      check({31'h0, irq}, 32'h0);
      rdChk(`NANDEC_OFF_MODE, 32'h0);
      check({30'h0, rsp}, 32'(nandec_pkg::NANDEC_OKAY));
      rdChk(`NANDEC_OFF_STAT_LOW, 32'h0);
      rdChk(`NANDEC_OFF_IRQ_STATUS, 32'h0);
      $display("test reset done");
   endtask : t_reset

   // Every correction type, flags and location
   task automatic t_modes();
      int nv;
      for (int m = 0; m < 4; m++) begin
         nv = (m == 1) ? 16 : (m == 2) ? 8 : 1;
         wr(`NANDEC_OFF_MODE, 32'(m) << 4);
         check({30'h0, correction_type}, 32'(m));
         page(FOUND_P, PBE_P, MANY_P, 12'hA5C, 4'h9);
         rdChk(`NANDEC_OFF_STAT_LOW, expStat(0, nv, FOUND_P, PBE_P, MANY_P));
         rdChk(`NANDEC_OFF_STAT_HIGH, expStat(8, nv, FOUND_P, PBE_P, MANY_P));
         rdChk(`NANDEC_OFF_LOCATION, (m == 0) ? 32'h0000A5C9 : 32'h0);
         page(16'h0, 16'h0, 16'h0, 12'h123, 4'h4);
         rdChk(`NANDEC_OFF_STAT_LOW, 32'h0);
      end
      $display("test modes done");
   endtask : t_modes

   // Parity clear, zero has no effect
   task automatic t_clear();
      int c0;
      wr(`NANDEC_OFF_MODE, 32'h10);
      page(FOUND_P, PBE_P, MANY_P, 12'h001, 4'h1);
      c0 = clrCnt;
      wr(`NANDEC_OFF_CTRL, 32'h0);
      check({30'h0, rsp}, 32'(nandec_pkg::NANDEC_OKAY));
      repeat (2) @(posedge clk_sys);
      check(32'(clrCnt - c0), 32'h0);
      rdChk(`NANDEC_OFF_STAT_HIGH, expStat(8, 16, FOUND_P, PBE_P, MANY_P));
      wr(`NANDEC_OFF_CTRL, 32'h1);
      repeat (2) @(posedge clk_sys);
      check(32'(clrCnt - c0), 32'h1);
      rdChk(`NANDEC_OFF_STAT_LOW, 32'h0);
      rdChk(`NANDEC_OFF_STAT_HIGH, 32'h0);
      $display("test clear done");
   endtask : t_clear

   // Interrupt raise, mask and clear
   task automatic t_irq();
      wr(`NANDEC_OFF_MODE, 32'h0);
      rdChk(`NANDEC_OFF_IRQ_STATUS, 32'h7);
      wr(`NANDEC_OFF_IRQ_CLEAR, 32'h7);
      page(16'h0001, 16'h0, 16'h0, 12'hFFF, 4'hF);
      rdChk(`NANDEC_OFF_IRQ_STATUS, 32'h3);
      rdChk(`NANDEC_OFF_LOCATION, 32'h0000FFFF);
      check({31'h0, irq}, 32'h0);
      wr(`NANDEC_OFF_IRQ_ENABLE, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(`NANDEC_OFF_IRQ_ENABLE, 32'h4);
      check({31'h0, irq}, 32'h0);
      wr(`NANDEC_OFF_IRQ_ENABLE, 32'h2);
      wr(`NANDEC_OFF_IRQ_CLEAR, 32'h2);
      check({31'h0, irq}, 32'h0);
      rdChk(`NANDEC_OFF_IRQ_STATUS, 32'h1);
      $display("test irq done");
   endtask : t_irq

   // Unmapped address
   task automatic t_bad();
      wr(8'h40, 32'hFFFFFFFF);
      check({30'h0, rsp}, 32'(nandec_pkg::NANDEC_SLVERR));
      rdChk(8'h40, 32'h0);
      check({30'h0, rsp}, 32'(nandec_pkg::NANDEC_SLVERR));
      $display("test unmapped done");
   endtask : t_bad

   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      clk_sys = 0; reset = 1; fails = 0; cmp_count = 0; clrCnt = 0;
      s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wstrb = 0;
      s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 0; s_axi_arvalid = 0;
      s_axi_rready = 0; pageCheckDone = 0; sectorErrorFound = 0;
      sectorParityByteErr = 0; sectorManyErrors = 0; failingWordIn = 0; failingBitIn = 0;
      repeat (10) @(posedge clk_sys);
      reset <= 0;
      t_reset();
      t_modes();
      t_clear();
      t_irq();
      t_bad();
      stop_test();
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      stop_test();
   end
endmodule : tb_top
